/* File: bench/ccd_fetch_model.sv */
// fetch stage stand-in: one word per request, after req_gap+1 idle cycles
// assumes req is a one-cycle pulse; word is junk while not valid
`timescale 1ns/1ps
module ccd_fetch_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic [13:0] req_word,
  input wire logic [1:0] req_gap,
  output logic instr_valid,
  output logic [13:0] instr_word
);
  logic busy;
  logic [1:0] cnt;
  logic [13:0] held;
  // idle word toggles so a stale value never looks like a real one
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      instr_valid <= 1'b0;
      instr_word <= 14'h0000;
      busy <= 1'b0;
      cnt <= 2'd0;
      held <= 14'h0000;
    end else begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
      if (req) begin
        busy <= 1'b1;
        cnt <= req_gap;
        held <= req_word;
      end else if (busy && cnt != 2'd0) begin
        cnt <= cnt - 2'd1;
      end else if (busy) begin
        instr_valid <= 1'b1;
        instr_word <= held;
        busy <= 1'b0;
      end
    end
  end
endmodule : ccd_fetch_model

/* File: bench/ccd_monitor.sv */
// checker for the executor: port-level relations of the four words
// bound to ccd_core; sees only its ports
`timescale 1ns/1ps
module ccd_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] work_value,
  input wire logic zero_flag,
  input wire logic timeout_status_flag,
  input wire logic powerdown_status_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic go;
  logic [5:0] hi;
  // a word counts only when the fetch side offers it and clocks run
  assign go = instr_valid && clk_en;
  assign hi = instr_word[13:8];
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_clear_working_reg_op;
    go && instr_word == ccd_pkg::OPC_CLEAR_W;
  endsequence
  sequence s_wdt;
    go && instr_word == ccd_pkg::OPC_WDT_CLEAR;
  endsequence
  sequence s_fop(d);
    go && instr_word[7] == d && (hi == ccd_pkg::OPC_DEC_HI || hi == ccd_pkg::OPC_COMP_HI);
  endsequence
  property p_clear_working_reg_op;
    s_clear_working_reg_op |=> work_value == 8'h00 && zero_flag;
  endproperty
  a_clear_working_reg_op: assert property (p_clear_working_reg_op) else $error("clear word left work or zero");
  property p_wdt_flags;
    s_wdt |=> timeout_status_flag && powerdown_status_flag;
  endproperty
  a_wdt_flags: assert property (p_wdt_flags) else $error("status flags not set");
  property p_wdt_zero;
    s_wdt |=> zero_flag == $past(zero_flag);
  endproperty
  a_wdt_zero: assert property (p_wdt_zero) else $error("zero moved on clear");
  // power-down is only ever set by this block
  property p_pd_hold;
    !$fell(powerdown_status_flag);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down dropped");
  property p_dest0;
    s_fop(1'b0) |=> zero_flag == (work_value == 8'h00);
  endproperty
  a_dest0: assert property (p_dest0) else $error("zero disagrees with work");
  property p_dest1;
    s_fop(1'b1) |=> work_value == $past(work_value);
  endproperty
  a_dest1: assert property (p_dest1) else $error("work hit by file dest");
  property p_ignored;
    go && instr_word[13:12] != 2'b00 |=> zero_flag == $past(zero_flag);
  endproperty
  a_ignored: assert property (p_ignored) else $error("foreign word acted");
  property p_frozen;
    !clk_en |=> work_value == $past(work_value) && zero_flag == $past(zero_flag);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while frozen");
endmodule : ccd_monitor

bind ccd_core ccd_monitor u_ccd_monitor (.core_clk, .sys_rst, .clk_en, .instr_valid,
  .instr_word, .work_value, .zero_flag, .timeout_status_flag, .powerdown_status_flag);

/* File: bench/clear_decrement_complement_exec_bench.sv */
// self-checking bench for ccd_core with a fetch model and a bus master
// assumes the register map and bus timing that ccd_core implements
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module clear_decrement_complement_exec_bench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic req = 1'b0;
  logic [13:0] req_word = 14'h0000;
  logic [1:0] req_gap = 2'd0;
  logic wdt_tick = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
  logic [31:0] s_axi_rdata, rd, rnd;
  logic instr_valid, zero_flag, timeout_status_flag, powerdown_status_flag;
  logic [13:0] instr_word;
  logic [7:0] work_value, fv, r, ref_w;
  logic [6:0] fa;
  logic [5:0] hi;
  logic d, ref_z;
  int error_cnt = 0, n_tests = 0, k;
  int seed = 32'h422b;

  always #12.5 core_clk = ~core_clk;
  ccd_core u_ccd_core (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr_word(instr_word), .wdt_tick(wdt_tick),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .work_value(work_value),
    .zero_flag(zero_flag), .timeout_status_flag(timeout_status_flag),
    .powerdown_status_flag(powerdown_status_flag)
  );
  ccd_fetch_model u_ccd_fetch_model (
    .core_clk(core_clk), .sys_rst(sys_rst), .req(req), .req_word(req_word),
    .req_gap(req_gap), .instr_valid(instr_valid), .instr_word(instr_word)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("comparisons %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // bus writes: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge core_clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        bs = s_axi_bresp;
        break;
      end
    end
    if (i == 64) begin error_cnt++; stop_test(); end
  endtask : wr
  task rd_t(input logic [7:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge core_clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        break;
      end
    end
    if (i == 64) begin error_cnt++; stop_test(); end
  endtask : rd_t
  // one word through the fetch model; returns at the edge that executes it
  task exe(input logic [13:0] w, input logic [1:0] g);
    int i;
    req <= 1'b1;
    req_word <= w;
    req_gap <= g;
    @(posedge core_clk);
    req <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge core_clk);
      if (instr_valid === 1'b1) break;
    end
    if (i == 8) begin error_cnt++; stop_test(); end
  endtask : exe
  task chk_state;
    rd_t(ccd_pkg::OFS_WORK);
    `CHK(rd, {24'h0, ref_w})
    `CHK(work_value, ref_w)
    rd_t(ccd_pkg::OFS_STATUS);
    `CHK(rd[0], ref_z)
    `CHK(zero_flag, ref_z)
  endtask : chk_state
  function automatic logic [7:0] res(input logic [5:0] h, input logic [7:0] v);
    return (h == ccd_pkg::OPC_DEC_HI) ? v - 8'h01 : ~v;
  endfunction : res
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd_t(ccd_pkg::OFS_STATUS);
    `CHK(rd, 32'h0000_0006)
    rd_t(8'h40);
    `CHK(rs, ccd_pkg::RESP_SLVERR)
    wr(8'h40, 32'h0000_0000);
    `CHK(bs, ccd_pkg::RESP_SLVERR)
    // file ops: address ends and zero-crossing values first, then random
    for (k = 0; k < 40; k++) begin
      rnd = $random(seed);
      fa = (k == 0) ? 7'd0 : (k == 1) ? 7'd127 : rnd[6:0];
      fv = (k == 0) ? 8'h01 : (k == 1) ? 8'hFF : (k == 2) ? 8'h00 : rnd[15:8];
      hi = k[0] ? ccd_pkg::OPC_COMP_HI : ccd_pkg::OPC_DEC_HI;
      d = rnd[16];
      wr(ccd_pkg::OFS_FADDR, {25'h0, fa});
      wr(ccd_pkg::OFS_FDATA, {24'h0, fv});
      ref_w = ~fv ^ rnd[31:24];
      wr(ccd_pkg::OFS_WORK, {24'h0, ref_w});
      exe({hi, d, fa}, rnd[18:17]);
      r = res(hi, fv);
      ref_z = (r == 8'h00);
      if (!d) ref_w = r;
      chk_state();
      rd_t(ccd_pkg::OFS_FDATA);
      `CHK(rd, {24'h0, d ? r : fv})
    end
    // foreign words, one a neighbour opcode, must do nothing
    for (k = 0; k < 2; k++) begin
      exe(k[0] ? 14'h2A5A : 14'h0B05, 2'd0);
      chk_state();
    end
    // clear word with clocks frozen is lost, then taken for real
    wr(ccd_pkg::OFS_WORK, 32'h0000_005A);
    `CHK(bs, ccd_pkg::RESP_OKAY)
    ref_w = 8'h5A;
    clk_en <= 1'b0;
    exe(ccd_pkg::OPC_CLEAR_W, 2'd0);
    clk_en <= 1'b1;
    chk_state();
    exe(ccd_pkg::OPC_CLEAR_W, 2'd3);
    ref_w = 8'h00;
    ref_z = 1'b1;
    chk_state();
    // a word queued over the bus runs in the first idle fetch cycle
    wr(ccd_pkg::OFS_WORK, 32'h0000_0033);
    wr(ccd_pkg::OFS_ISSUE, {18'h0, ccd_pkg::OPC_CLEAR_W});
    rd_t(ccd_pkg::OFS_ISSUE);
    `CHK(rd, {18'h0, ccd_pkg::OPC_CLEAR_W})
    chk_state();
    // run the watchdog through one overflow so timeout really drops
    wdt_tick <= 1'b1;
    repeat (65836) @(posedge core_clk);
    wdt_tick <= 1'b0;
    rd_t(ccd_pkg::OFS_WDOG);
    `CHK(rd, 32'h0000_2C01)
    rd_t(ccd_pkg::OFS_STATUS);
    `CHK(rd, 32'h0000_0005)
    exe(ccd_pkg::OPC_WDT_CLEAR, 2'd1);
    rd_t(ccd_pkg::OFS_WDOG);
    `CHK(rd[7:0], ccd_pkg::WDOG_CLEAR_VAL)
    `CHK(rd[15:8], 8'h00)
    rd_t(ccd_pkg::OFS_STATUS);
    `CHK(rd, 32'h0000_0007)
    `CHK({powerdown_status_flag, timeout_status_flag}, 2'b11)
    // with the watchdog disabled, ticks must leave it at zero
    wr(ccd_pkg::OFS_CTRL, 32'h0000_0000);
    wdt_tick <= 1'b1;
    repeat (4) @(posedge core_clk);
    wdt_tick <= 1'b0;
    rd_t(ccd_pkg::OFS_WDOG);
    `CHK(rd, 32'h0000_0000)
    stop_test();
  end
endmodule : clear_decrement_complement_exec_bench

/* File: logic/ccd_core.sv */
// executor for clear-working, watchdog-clear, decrement-file and complement-file
// assumes fetch words are synchronous to core_clk; registers reached over AXI4-Lite
//
// Summary of operation
// RULE1: the clear-working word loads zero into the working register and sets zero.
// RULE2: the watchdog-clear word resets the watchdog counter to zero.
// RULE3: the watchdog-clear word clears the watchdog prescaler in the same cycle.
// RULE4: the watchdog-clear word sets the timeout and power-down flags and leaves zero unchanged.
// RULE5: complement inverts the addressed file register and sets zero from the result.
// RULE6: destination bit zero writes the working register, one writes the file register.
// RULE7: decrement subtracts one from the file register, routes it and updates zero.
// RULE8: decrement and complement carry a 7-bit file address and one destination bit.
// RULE9: each of the four executes in one cycle; zero is set exactly when result is zero.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module ccd_core (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic wdt_tick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] work_value,
  output logic zero_flag,
  output logic timeout_status_flag,
  output logic powerdown_status_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] file_mem [0:127];
  logic [7:0] work_reg, work_next;
  logic zero_reg, zero_next;
  logic timeout_reg, timeout_next;
  logic powerdown_reg, powerdown_next;
  logic wdt_en_reg, wdt_en_next;
  logic [13:0] issue_reg, issue_next;
  logic pend_reg, pend_next;
  logic [6:0] faddr_reg, faddr_next;
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic file_we;
  logic [6:0] file_wa;
  logic [7:0] file_wd;
  logic exec;
  logic [13:0] exec_word;
  ccd_pkg::ccd_op_t op;
  logic dest;
  logic [6:0] op_faddr;
  logic [7:0] operand;
  logic [7:0] result;
  logic wd_clear;
  logic [7:0] wd_count;
  logic [7:0] wd_prescale;
  logic wd_overflow;
  logic do_write;
  logic [31:0] merged;
  logic aw_take, w_take, ar_take;

  // merge the write data into an old value by byte lane
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  ////////////////////////////////////////////////////////////////////////////////
  // instruction source and decode
  // the fetch port wins; a word queued by software waits for an idle cycle
  assign exec = instr_valid | pend_reg;
  assign exec_word = instr_valid ? instr_word : issue_reg;

  ccd_decode u_decode (
    .instr(exec_word),
    .op(op),
    .dest(dest),
    .faddr(op_faddr)
  );

  assign operand = file_mem[op_faddr];
  assign wd_clear = exec && (op == ccd_pkg::CCD_OP_WDT_CLEAR); // RULE2 RULE3

  ccd_watchdog u_watchdog (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .enable(wdt_en_reg),
    .tick(wdt_tick),
    .clear(wd_clear),
    .count(wd_count),
    .prescale(wd_prescale),
    .overflow(wd_overflow)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus write channel bookkeeping; aw and w may arrive in either order
  always_comb begin
    aw_take = s_axi_awvalid & awready_reg;
    w_take = s_axi_wvalid & wready_reg;
    do_write = aw_have_reg & w_have_reg;
    aw_have_next = do_write ? 1'b0 : (aw_have_reg | aw_take);
    w_have_next = do_write ? 1'b0 : (w_have_reg | w_take);
    awaddr_next = aw_take ? s_axi_awaddr : awaddr_reg;
    wdata_next = w_take ? s_axi_wdata : wdata_reg;
    wstrb_next = w_take ? s_axi_wstrb : wstrb_reg;
    bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
    bresp_next = bresp_reg;
    awready_next = ~aw_have_next & ~bvalid_next;
    wready_next = ~w_have_next & ~bvalid_next;
    if (do_write) begin
      case (awaddr_reg)
        ccd_pkg::OFS_CTRL, ccd_pkg::OFS_ISSUE, ccd_pkg::OFS_WORK, ccd_pkg::OFS_STATUS,
        ccd_pkg::OFS_WDOG, ccd_pkg::OFS_FADDR, ccd_pkg::OFS_FDATA: begin
          bresp_next = ccd_pkg::RESP_OKAY;
        end
        default: begin
          bresp_next = ccd_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // execution and register writes
  // execution has priority over a software write to the same state
  always_comb begin
    work_next = work_reg;
    zero_next = zero_reg;
    timeout_next = timeout_reg;
    powerdown_next = powerdown_reg;
    wdt_en_next = wdt_en_reg;
    issue_next = issue_reg;
    pend_next = pend_reg & instr_valid; // queued word retires when it runs
    faddr_next = faddr_reg;
    file_we = 1'b0;
    file_wa = op_faddr;
    file_wd = 8'h00;
    result = 8'h00;
    merged = 32'h0000_0000;
    // an overflow means the watchdog ran out
    if (wd_overflow) begin
      timeout_next = 1'b0;
    end
    // software side first so that execution below overrides it
    if (do_write) begin
      case (awaddr_reg)
        ccd_pkg::OFS_CTRL: begin
          merged = lane_merge({31'h0, wdt_en_reg}, wdata_reg, wstrb_reg);
          wdt_en_next = merged[ccd_pkg::CTRL_WDT_EN_POS];
        end
        ccd_pkg::OFS_ISSUE: begin
          merged = lane_merge({18'h0, issue_reg}, wdata_reg, wstrb_reg);
          issue_next = merged[13:0];
          pend_next = 1'b1;
        end
        ccd_pkg::OFS_WORK: begin
          merged = lane_merge({24'h0, work_reg}, wdata_reg, wstrb_reg);
          work_next = merged[7:0];
        end
        ccd_pkg::OFS_FADDR: begin
          merged = lane_merge({25'h0, faddr_reg}, wdata_reg, wstrb_reg);
          faddr_next = merged[6:0];
        end
        ccd_pkg::OFS_FDATA: begin
          merged = lane_merge({24'h0, file_mem[faddr_reg]}, wdata_reg, wstrb_reg);
          file_we = 1'b1;
          file_wa = faddr_reg;
          file_wd = merged[7:0];
        end
        default: begin
          merged = 32'h0000_0000; // status and watchdog are read only
        end
      endcase
    end
    if (exec) begin
      case (op)
        ccd_pkg::CCD_OP_CLEAR_W: begin
          work_next = 8'h00; // RULE1 RULE9
          zero_next = 1'b1; // RULE1
        end
        ccd_pkg::CCD_OP_WDT_CLEAR: begin
          timeout_next = 1'b1; // RULE4
          powerdown_next = 1'b1; // RULE4
        end
        ccd_pkg::CCD_OP_DEC, ccd_pkg::CCD_OP_COMP: begin
          if (op == ccd_pkg::CCD_OP_DEC) begin
            result = operand - 8'h01; // RULE7
          end else begin
            result = ~operand; // RULE5
          end
          zero_next = (result == 8'h00); // RULE5 RULE7 RULE9
          if (dest) begin
            file_we = 1'b1; // RULE6
            file_wa = op_faddr; // RULE8
            file_wd = result;
          end else begin
            work_next = result; // RULE6
          end
        end
        default: begin
          result = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus read channel; one outstanding read, answered the cycle after the take
  always_comb begin
    ar_take = s_axi_arvalid & arready_reg;
    rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
    arready_next = ~rvalid_next;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      rresp_next = ccd_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ccd_pkg::OFS_CTRL: rdata_next = {31'h0, wdt_en_reg};
        ccd_pkg::OFS_ISSUE: rdata_next = {15'h0, pend_reg, 2'h0, issue_reg};
        ccd_pkg::OFS_WORK: rdata_next = {24'h0, work_reg};
        ccd_pkg::OFS_STATUS: rdata_next = {29'h0, powerdown_reg, timeout_reg, zero_reg};
        ccd_pkg::OFS_WDOG: rdata_next = {16'h0, wd_prescale, wd_count};
        ccd_pkg::OFS_FADDR: rdata_next = {25'h0, faddr_reg};
        ccd_pkg::OFS_FDATA: rdata_next = {24'h0, file_mem[faddr_reg]};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = ccd_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // file registers keep their contents through reset, as ram would
  always_ff @(posedge core_clk) begin
    if (clk_en && file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end

  // core state and bus registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      work_reg <= ccd_pkg::RST_WORK;
      zero_reg <= ccd_pkg::RST_ZERO;
      timeout_reg <= ccd_pkg::RST_TIMEOUT;
      powerdown_reg <= ccd_pkg::RST_POWERDOWN;
      wdt_en_reg <= ccd_pkg::RST_WDT_EN;
      issue_reg <= 14'h0000;
      pend_reg <= 1'b0;
      faddr_reg <= 7'h00;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= ccd_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= ccd_pkg::RESP_OKAY;
    end else if (clk_en) begin
      work_reg <= work_next;
      zero_reg <= zero_next;
      timeout_reg <= timeout_next;
      powerdown_reg <= powerdown_next;
      wdt_en_reg <= wdt_en_next;
      issue_reg <= issue_next;
      pend_reg <= pend_next;
      faddr_reg <= faddr_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign work_value = work_reg;
  assign zero_flag = zero_reg;
  assign timeout_status_flag = timeout_reg;
  assign powerdown_status_flag = powerdown_reg;

endmodule : ccd_core

/* File: logic/ccd_decode.sv */
// combinational decode of one instruction word into operation and fields
// assumes the word is stable for the cycle in which it executes
`timescale 1ns/1ps
module ccd_decode (
  input wire logic [13:0] instr,
  output ccd_pkg::ccd_op_t op,
  output logic dest,
  output logic [6:0] faddr
);

  // fixed words first, then the two file-register groups
  always_comb begin
    dest = instr[ccd_pkg::DEST_POS]; // RULE8
    faddr = instr[6:0]; // RULE8
    if (instr == ccd_pkg::OPC_CLEAR_W) begin
      op = ccd_pkg::CCD_OP_CLEAR_W; // RULE1
    end else if (instr == ccd_pkg::OPC_WDT_CLEAR) begin
      op = ccd_pkg::CCD_OP_WDT_CLEAR; // RULE2
    end else if (instr[13:ccd_pkg::OPC_HI_POS] == ccd_pkg::OPC_DEC_HI) begin
      op = ccd_pkg::CCD_OP_DEC; // RULE7
    end else if (instr[13:ccd_pkg::OPC_HI_POS] == ccd_pkg::OPC_COMP_HI) begin
      op = ccd_pkg::CCD_OP_COMP; // RULE5
    end else begin
      op = ccd_pkg::CCD_OP_NONE; // other words are left to other blocks
    end
  end

endmodule : ccd_decode

/* File: logic/ccd_pkg.sv */
// constants and types shared by the clear/decrement/complement executor
// assumes a 14-bit instruction word and an 8-bit data path
package ccd_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int ADDR_W = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // instruction encodings
  localparam logic [13:0] OPC_CLEAR_W = 14'h0103;
  localparam logic [13:0] OPC_WDT_CLEAR = 14'h0064;
  localparam logic [5:0] OPC_DEC_HI = 6'h03;
  localparam logic [5:0] OPC_COMP_HI = 6'h09;
  localparam int OPC_HI_POS = 8;
  localparam int DEST_POS = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ISSUE = 8'h04;
  localparam logic [7:0] OFS_WORK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_WDOG = 8'h10;
  localparam logic [7:0] OFS_FADDR = 8'h14;
  localparam logic [7:0] OFS_FDATA = 8'h18;

  // field positions
  localparam int CTRL_WDT_EN_POS = 0;
  localparam int ISSUE_PEND_POS = 16;
  localparam int ST_ZERO_POS = 0;
  localparam int ST_TO_POS = 1;
  localparam int ST_PD_POS = 2;
  localparam int WDOG_PRE_POS = 8;

  // reset, clear and limit values
  localparam logic RST_WDT_EN = 1'b1;
  localparam logic RST_ZERO = 1'b0;
  localparam logic RST_TIMEOUT = 1'b1;
  localparam logic RST_POWERDOWN = 1'b1;
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [7:0] WDOG_CLEAR_VAL = 8'h00;
  localparam logic [7:0] PRESCALE_MAX = 8'hFF;
  localparam logic [7:0] WDOG_MAX = 8'hFF;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    CCD_OP_NONE = 3'b000,
    CCD_OP_CLEAR_W = 3'b001,
    CCD_OP_WDT_CLEAR = 3'b010,
    CCD_OP_DEC = 3'b011,
    CCD_OP_COMP = 3'b100
  } ccd_op_t;

endpackage : ccd_pkg

/* File: logic/ccd_watchdog.sv */
// watchdog counter with its own prescaler
// assumes tick is a one-cycle pulse synchronous to core_clk
`timescale 1ns/1ps
module ccd_watchdog (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic tick,
  input wire logic clear,
  output logic [7:0] count,
  output logic [7:0] prescale,
  output logic overflow
);

  logic [7:0] count_next;
  logic [7:0] prescale_next;
  logic overflow_next;

  // clear beats a tick in the same cycle so a cleared watchdog restarts cleanly
  always_comb begin
    count_next = count;
    prescale_next = prescale;
    overflow_next = 1'b0;
    if (clear) begin
      count_next = ccd_pkg::WDOG_CLEAR_VAL; // RULE2
      prescale_next = ccd_pkg::WDOG_CLEAR_VAL; // RULE3
    end else if (enable && tick) begin
      prescale_next = prescale + 8'h01;
      if (prescale == ccd_pkg::PRESCALE_MAX) begin
        count_next = count + 8'h01;
        overflow_next = (count == ccd_pkg::WDOG_MAX);
      end
    end
  end

  // state registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 8'h00;
      prescale <= 8'h00;
      overflow <= 1'b0;
    end else if (clk_en) begin
      count <= count_next;
      prescale <= prescale_next;
      overflow <= overflow_next;
    end
  end

endmodule : ccd_watchdog
